// *** hdl/bidir_latch_flop_transceiver.sv ***
// top of the 18-bit latch/flip-flop bus transceiver
// Contract
// - two 18-bit paths, bits treated alike
// - latch enable high passes A to B
// - latch low, clock steady holds value
// - falling clock with enable captures A
// - clock enable high ignores the clock
// - active-low output enable, else high-impedance
// - B-to-A path mirrors A-to-B path
// - clock low before latch falls
`timescale 1ns/1ps
module bidir_latch_flop_transceiver
    import xcvr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // port a pins
    input wire logic [DATA_W-1:0] a_i,
    output logic [DATA_W-1:0] a_o,
    output logic [DATA_W-1:0] a_oe_o,
    // port b pins
    input wire logic [DATA_W-1:0] b_i,
    output logic [DATA_W-1:0] b_o,
    output logic [DATA_W-1:0] b_oe_o,
    // a-to-b controls
    input wire logic ab_out_en_n_i,
    input wire logic ab_latch_en_i,
    input wire logic ab_clk_i,
    input wire logic ab_clk_en_n_i,
    // b-to-a controls
    input wire logic ba_out_en_n_i,
    input wire logic ba_latch_en_i,
    input wire logic ba_clk_i,
    input wire logic ba_clk_en_n_i
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // two flops on every data and control pin before any logic looks at it; rst_b_i is used directly

    // port a data
    logic [DATA_W-1:0] a_meta_reg;
    logic [DATA_W-1:0] a_sync_reg;

    // port b data
    logic [DATA_W-1:0] b_meta_reg;
    logic [DATA_W-1:0] b_sync_reg;

    // a-to-b controls
    logic ab_out_en_n_meta_reg;
    logic ab_out_en_n_sync_reg;
    logic ab_latch_en_meta_reg;
    logic ab_latch_en_sync_reg;
    logic ab_clk_meta_reg;
    logic ab_clk_sync_reg;
    logic ab_clk_en_n_meta_reg;
    logic ab_clk_en_n_sync_reg;

    // b-to-a controls
    logic ba_out_en_n_meta_reg;
    logic ba_out_en_n_sync_reg;
    logic ba_latch_en_meta_reg;
    logic ba_latch_en_sync_reg;
    logic ba_clk_meta_reg;
    logic ba_clk_sync_reg;
    logic ba_clk_en_n_meta_reg;
    logic ba_clk_en_n_sync_reg;

    // ----------------------------------------
    // data pins
    // ----------------------------------------
    // data reset to the stored reset value
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            a_meta_reg <= STORE_RESET;
            a_sync_reg <= STORE_RESET;
        end else begin
            a_meta_reg <= a_i;
            a_sync_reg <= a_meta_reg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            b_meta_reg <= STORE_RESET;
            b_sync_reg <= STORE_RESET;
        end else begin
            b_meta_reg <= b_i;
            b_sync_reg <= b_meta_reg;
        end
    end

    // ----------------------------------------
    // a-to-b control pins
    // ----------------------------------------
    // reset values keep the path disabled and holding
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            ab_out_en_n_meta_reg <= ~OUT_EN_ACTIVE;
            ab_out_en_n_sync_reg <= ~OUT_EN_ACTIVE;
        end else begin
            ab_out_en_n_meta_reg <= ab_out_en_n_i;
            ab_out_en_n_sync_reg <= ab_out_en_n_meta_reg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            ab_latch_en_meta_reg <= ~LATCH_OPEN;
            ab_latch_en_sync_reg <= ~LATCH_OPEN;
        end else begin
            ab_latch_en_meta_reg <= ab_latch_en_i;
            ab_latch_en_sync_reg <= ab_latch_en_meta_reg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            ab_clk_meta_reg <= CLK_IDLE;
            ab_clk_sync_reg <= CLK_IDLE;
        end else begin
            ab_clk_meta_reg <= ab_clk_i;
            ab_clk_sync_reg <= ab_clk_meta_reg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            ab_clk_en_n_meta_reg <= ~CLK_EN_ACTIVE;
            ab_clk_en_n_sync_reg <= ~CLK_EN_ACTIVE;
        end else begin
            ab_clk_en_n_meta_reg <= ab_clk_en_n_i;
            ab_clk_en_n_sync_reg <= ab_clk_en_n_meta_reg;
        end
    end

    // ----------------------------------------
    // b-to-a control pins
    // ----------------------------------------
    // same reset levels as the a-to-b side
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            ba_out_en_n_meta_reg <= ~OUT_EN_ACTIVE;
            ba_out_en_n_sync_reg <= ~OUT_EN_ACTIVE;
        end else begin
            ba_out_en_n_meta_reg <= ba_out_en_n_i;
            ba_out_en_n_sync_reg <= ba_out_en_n_meta_reg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            ba_latch_en_meta_reg <= ~LATCH_OPEN;
            ba_latch_en_sync_reg <= ~LATCH_OPEN;
        end else begin
            ba_latch_en_meta_reg <= ba_latch_en_i;
            ba_latch_en_sync_reg <= ba_latch_en_meta_reg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            ba_clk_meta_reg <= CLK_IDLE;
            ba_clk_sync_reg <= CLK_IDLE;
        end else begin
            ba_clk_meta_reg <= ba_clk_i;
            ba_clk_sync_reg <= ba_clk_meta_reg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            ba_clk_en_n_meta_reg <= ~CLK_EN_ACTIVE;
            ba_clk_en_n_sync_reg <= ~CLK_EN_ACTIVE;
        end else begin
            ba_clk_en_n_meta_reg <= ba_clk_en_n_i;
            ba_clk_en_n_sync_reg <= ba_clk_en_n_meta_reg;
        end
    end

    // ----------------------------------------
    // two paths
    // ----------------------------------------
    // port a data drives port b
    xcvr_path u_ab (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .out_en_n_i(ab_out_en_n_sync_reg),
        .latch_en_i(ab_latch_en_sync_reg),
        .clk_i(ab_clk_sync_reg),
        .clk_en_n_i(ab_clk_en_n_sync_reg),
        .src_i(a_sync_reg),
        .dst_o(b_o),
        .dst_oe_o(b_oe_o)
    );

    // port b data drives port a
    xcvr_path u_ba (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .out_en_n_i(ba_out_en_n_sync_reg),
        .latch_en_i(ba_latch_en_sync_reg),
        .clk_i(ba_clk_sync_reg),
        .clk_en_n_i(ba_clk_en_n_sync_reg),
        .src_i(b_sync_reg),
        .dst_o(a_o),
        .dst_oe_o(a_oe_o)
    );
endmodule // bidir_latch_flop_transceiver

// *** include/xcvr_pkg.sv ***
// package with widths and control levels of the two-way transceiver
package xcvr_pkg;
    localparam int unsigned DATA_W = 18;
    localparam logic OUT_EN_ACTIVE = 1'b0;
    localparam logic CLK_EN_ACTIVE = 1'b0;
    localparam logic LATCH_OPEN = 1'b1;
    localparam logic CLK_IDLE = 1'b0;
    localparam logic [DATA_W-1:0] STORE_RESET = 18'h00000;
    localparam int unsigned SYNC_STAGES = 2;
endpackage

// *** hdl/xcvr_path.sv ***
// one direction of the transceiver: storage element and output driver
`timescale 1ns/1ps
module xcvr_path
    import xcvr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // synchronised controls
    input wire logic out_en_n_i,
    input wire logic latch_en_i,
    input wire logic clk_i,
    input wire logic clk_en_n_i,
    // synchronised source data
    input wire logic [DATA_W-1:0] src_i,
    // driven side
    output logic [DATA_W-1:0] dst_o,
    output logic [DATA_W-1:0] dst_oe_o
);
    logic [DATA_W-1:0] store_reg;
    logic clk_prev_reg;
    logic fall;

    assign fall = clk_prev_reg & ~clk_i;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            clk_prev_reg <= CLK_IDLE;
        end else begin
            clk_prev_reg <= clk_i;
        end
    end

    // storage keeps updating whatever the output enable says
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            store_reg <= STORE_RESET;
        end else if (latch_en_i == LATCH_OPEN) begin
            store_reg <= src_i;
        end else if (fall && clk_en_n_i == CLK_EN_ACTIVE) begin
            store_reg <= src_i;
        end
    end

    // transparent mode registers the source, so it shows one ref_clk_i cycle later
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            dst_o <= STORE_RESET;
            dst_oe_o <= '0;
        end else begin
            if (latch_en_i == LATCH_OPEN) begin
                dst_o <= src_i;
            end else if (fall && clk_en_n_i == CLK_EN_ACTIVE) begin
                dst_o <= src_i;
            end else begin
                dst_o <= store_reg;
            end
            dst_oe_o <= {DATA_W{out_en_n_i == OUT_EN_ACTIVE}};
        end
    end
endmodule // xcvr_path

// *** verification/bus_side.sv ***
// far-side bus logic resolving ports a and b
`timescale 1ns/1ps
module bus_side
    import xcvr_pkg::*;
(
    // device drivers
    input wire logic [DATA_W-1:0] da_i,
    input wire logic [DATA_W-1:0] dae_i,
    input wire logic [DATA_W-1:0] db_i,
    input wire logic [DATA_W-1:0] dbe_i,
    // far-side values
    input wire logic [DATA_W-1:0] fa_i,
    input wire logic [DATA_W-1:0] fb_i,
    // wire levels
    output logic [DATA_W-1:0] pa_o,
    output logic [DATA_W-1:0] pb_o
);
    // far side lets go wherever the device drives
    assign pa_o = (dae_i & da_i) | (~dae_i & fa_i);
    assign pb_o = (dbe_i & db_i) | (~dbe_i & fb_i);
endmodule // bus_side

// *** verification/xcvr_assertions.sv ***
// port checker of the transceiver
`timescale 1ns/1ps
module xcvr_chk
    import xcvr_pkg::*;
(
    // clock, reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // pins
    input wire logic [DATA_W-1:0] a_i,
    input wire logic [DATA_W-1:0] a_o,
    input wire logic [DATA_W-1:0] a_oe_o,
    input wire logic [DATA_W-1:0] b_i,
    input wire logic [DATA_W-1:0] b_o,
    input wire logic [DATA_W-1:0] b_oe_o,
    // controls
    input wire logic ab_out_en_n_i,
    input wire logic ab_latch_en_i,
    input wire logic ab_clk_en_n_i,
    input wire logic ba_out_en_n_i,
    input wire logic ba_latch_en_i
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence ab_open; ab_latch_en_i && !ab_out_en_n_i ##3 1; endsequence
    sequence ba_open; ba_latch_en_i && !ba_out_en_n_i ##3 1; endsequence
    sequence ba_on; !ba_out_en_n_i ##3 1; endsequence
    a_ab_pass: assert property (ab_open |-> b_o == $past(a_i, 3))
        else $error("b not following a");
    a_ba_pass: assert property (ba_open |-> a_o == $past(b_i, 3))
        else $error("a not following b");
    a_ab_drive: assert property (!ab_out_en_n_i ##3 1 |-> b_oe_o == '1)
        else $error("b not driven");
    a_ab_float: assert property (ab_out_en_n_i ##3 1 |-> b_oe_o == '0)
        else $error("b not released");
    a_ba_drive: assert property (ba_on |-> a_oe_o == '1)
        else $error("a not driven");
    a_ab_hold: assert property ((!ab_latch_en_i && ab_clk_en_n_i)[*2] ##3 1 |-> $stable(b_o))
        else $error("b changed while held");
endmodule // xcvr_chk
bind bidir_latch_flop_transceiver xcvr_chk i_chk (.*);

// *** verification/bidir_latch_flop_transceiver_tb_top.sv ***
// self-checking bench of the transceiver
`timescale 1ns/1ps
module bidir_latch_flop_transceiver_tb_top;
    import xcvr_pkg::*;
    logic ref_clk_i = 0, rst_b_i = 0;
    logic ab_out_en_n_i = 1, ab_latch_en_i = 1, ab_clk_i = 0, ab_clk_en_n_i = 1;
    logic ba_out_en_n_i = 1, ba_latch_en_i = 1, ba_clk_i = 0, ba_clk_en_n_i = 1;
    logic [DATA_W-1:0] a_i, a_o, a_oe_o, b_i, b_o, b_oe_o, fa = 0, fb = 0;
    logic [DATA_W-1:0] rows [4] = '{18'h00000, 18'h3ffff, 18'h2aaaa, 18'h15555};
    int error_cnt = 0, tests_run = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    bidir_latch_flop_transceiver i_dut (.*);
    bus_side i_far (.da_i(a_o), .dae_i(a_oe_o), .db_i(b_o), .dbe_i(b_oe_o),
        .fa_i(fa), .fb_i(fb), .pa_o(a_i), .pb_o(b_i));
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic chk(input string s, input logic [DATA_W-1:0] e, g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #10us error_cnt++;
        print_verdict;
    end
    initial begin
        w(3);
        rst_b_i <= 1;
        foreach (rows[i]) begin
            fa <= rows[i];
            fb <= ~rows[i];
            ab_out_en_n_i <= 0;
            ba_out_en_n_i <= 1;
            w(8);
            chk("b_o", rows[i], b_o);
            chk("b_oe", '1, b_oe_o);
            chk("a_oe", '0, a_oe_o);
            ab_out_en_n_i <= 1;
            ba_out_en_n_i <= 0;
            w(8);
            chk("a_o", ~rows[i], a_o);
            chk("b_oe", '0, b_oe_o);
            chk("a_oe", '1, a_oe_o);
        end
        $display("rows done");
        ab_out_en_n_i <= 0;
        ba_out_en_n_i <= 1;
        fa <= 18'h12345;
        w(8);
        ab_latch_en_i <= 0;
        ab_clk_en_n_i <= 0;
        ab_clk_i <= 1;
        fa <= 18'h0f0f0;
        w(8);
        chk("b_o", 18'h12345, b_o);
        ab_clk_i <= 0;
        w(3);
        fa <= 18'h0abcd;
        w(8);
        chk("b_o", 18'h0f0f0, b_o);
        ab_clk_en_n_i <= 1;
        ab_clk_i <= 1;
        w(3);
        ab_clk_i <= 0;
        w(8);
        chk("b_o", 18'h0f0f0, b_o);
        ab_out_en_n_i <= 1;
        ab_clk_en_n_i <= 0;
        ab_clk_i <= 1;
        w(3);
        ab_clk_i <= 0;
        w(3);
        ab_out_en_n_i <= 0;
        w(8);
        chk("b_o", 18'h0abcd, b_o);
        $display("clocked done");
        rst_b_i <= 0;
        w(3);
        chk("b_oe", '0, b_oe_o);
        chk("b_o", '0, b_o);
        rst_b_i <= 1;
        w(8);
        chk("b_o", '0, b_o);
        chk("b_oe", '1, b_oe_o);
        ab_latch_en_i <= 1;
        w(8);
        chk("b_o", 18'h0abcd, b_o);
        $display("reset done");
        print_verdict;
    end
endmodule // bidir_latch_flop_transceiver_tb_top
